//--- sisl_pkg.sv
// package: register map, field positions, reset values, state encodings and carriers for the sisl block
// Function
// - first status register shows requests one to six in bits 7..2, bits 1..0 zero
// - second status register shows requests seven to eleven, read only
// - third status register always reads zero
// - arbitration serves the lowest priority number first
// - global mask blocks all sources except the software interrupt
// - all resets share equal priority above every interrupt
// - break request forces the cpu to the software interrupt vector
// - in break, other flags clear only when break clear enable is one
// - a flag cleared in break stays cleared after break
// - two-step clears stay protected in break, complete normally afterwards
// - wait or stop clears the global interrupt mask
// - wait gates cpu clocks, peripheral clocks keep running
// - interrupt, reset or break ends wait; stacking one cycle later
// - break during wait or stop sets the break lowpower flag
// - watchdog runs in wait when the disable option is zero
// - stop resets the counter and gates all system clocks
// - stop recovery lasts 4096 cycles, or 32 with short recovery set
// - interrupt, reset or break ends stop; stacking after recovery
// - counter held in reset during stop, then times recovery
// - break lowpower flag cleared by writing zero or by reset
// - reset status holds six source flags, cleared by reading
// - power-on sets its flag and clears others; others set their own
package sisl_pkg;
  localparam logic [15:0] OFS_BREAK_STATUS  = 16'hFE00;
  localparam logic [15:0] OFS_RESET_STATUS  = 16'hFE01;
  localparam logic [15:0] OFS_BREAK_FLAG    = 16'hFE03;
  localparam logic [15:0] OFS_INT_ONE       = 16'hFE04;
  localparam logic [15:0] OFS_INT_TWO       = 16'hFE05;
  localparam logic [15:0] OFS_INT_THREE     = 16'hFE06;
  localparam logic [15:0] OFS_LOWPOWER_CTRL = 16'hFE08;
  localparam int          POS_BRK_LP        = 1;
  localparam int          POS_CLR_EN        = 7;
  localparam int          POS_INT_LOW       = 2;
  localparam logic [7:0]  RST_INT_ONE       = 8'h00;
  localparam logic [7:0]  RST_BREAK_FLAG    = 8'h00;
  localparam int          NUM_SRC           = 11;
  localparam int          STOP_LONG_CYC     = 4096;
  localparam int          STOP_SHORT_CYC    = 32;
  localparam logic [12:0] CNT_ZERO          = 13'h0000;
  localparam logic [3:0]  LP_WAIT_CMD       = 4'h1;
  localparam logic [3:0]  LP_STOP_CMD       = 4'h2;

  typedef enum logic [1:0] {
    SISL_RUN  = 2'b00,
    SISL_WAIT = 2'b01,
    SISL_STOP = 2'b11,
    SISL_REC  = 2'b10
  } sisl_mode_type;

  // reset sources in flag order of the reset status register
  typedef struct packed {
    logic power_on;
    logic pin;
    logic watchdog;
    logic bad_opcode;
    logic bad_fetch;
    logic serial_bus;
  } sisl_rstsrc_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } sisl_apb_req_type;
endpackage

//--- sisl_top.sv
// module: system integration status, reset source, break and low-power sequencing with apb registers
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
module sisl_top (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire sisl_pkg::sisl_apb_req_type apb_req,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [10:0]               src_request,
  input  wire logic [10:0]               src_enable,
  input  wire logic                      cpu_mask_in,
  input  wire logic                      soft_int_request,
  input  wire logic                      break_request,
  input  wire logic                      wait_exec,
  input  wire logic                      stop_exec,
  input  wire logic                      short_stop_recovery,
  input  wire logic                      watchdog_disable_option,
  input  wire sisl_pkg::sisl_rstsrc_type  reset_events,
  output logic                           cpu_mask_clear,
  output logic                           cpu_clock_en,
  output logic                           periph_clock_en,
  output logic                           base_clock_out_en,
  output logic                           crystal_clock_en,
  output logic                           watchdog_run,
  output logic                           vector_take,
  output logic [3:0]                     vector_index,
  output logic                           force_soft_vector,
  output logic                           in_break,
  output logic                           flag_clear_allowed
);
  localparam logic [12:0] LONG_CNT  = 13'(sisl_pkg::STOP_LONG_CYC - 1);
  localparam logic [12:0] SHORT_CNT = 13'(sisl_pkg::STOP_SHORT_CYC - 1);

  typedef struct packed {
    sisl_pkg::sisl_mode_type  mode;
    logic [12:0]              cnt;
    logic                     brk_lp;
    logic                     clr_en;
    logic                     brk;
    sisl_pkg::sisl_rstsrc_type reset_source_status;
    logic [10:0]              req;
    logic [31:0]              rdata;
    logic                     take;
    logic [3:0]               vec;
    logic                     mclr;
  } sisl_state_type;

  sisl_state_type s;
  sisl_state_type next_s;

  // lowest index wins, so source one is served first
  function automatic logic [3:0] sisl_prio(input logic [10:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 10; i >= 0; i--) begin
      if (v[i]) r = 4'(i + 1);
    end
    return r;
  endfunction

  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic [10:0] pend;
  logic        any_rst;
  assign acc     = apb_req.psel && apb_req.penable;
  assign wr_acc  = acc && apb_req.pwrite;
  assign rd_acc  = acc && !apb_req.pwrite;
  // global mask gates all maskable sources, software interrupt passes
  // live levels, and no source take in the cycle after a take, so an acknowledged source drops out before it can be taken twice
  assign pend    = (cpu_mask_in ? 11'h000 : (src_request & src_enable));
  assign any_rst = |reset_events;

  // next state: registers, mode sequencing, vector selection
  always_comb begin
    next_s       = s;
    next_s.take  = 1'b0;
    next_s.mclr  = 1'b0;
    next_s.req   = src_request;
    next_s.brk   = break_request;
    if (wr_acc && apb_req.paddr == sisl_pkg::OFS_BREAK_FLAG) begin
      next_s.clr_en = apb_req.pwdata[sisl_pkg::POS_CLR_EN];
    end
    if (wr_acc && apb_req.paddr == sisl_pkg::OFS_BREAK_STATUS && !apb_req.pwdata[sisl_pkg::POS_BRK_LP]) begin
      next_s.brk_lp = 1'b0;
    end
    // read clears reset sources; a new reset event wins over the clear
    if (rd_acc && apb_req.paddr == sisl_pkg::OFS_RESET_STATUS) begin
      next_s.reset_source_status = '0;
    end
    if (reset_events.power_on) begin
      next_s.reset_source_status = '0;
      next_s.reset_source_status.power_on = 1'b1;
    end else begin
      next_s.reset_source_status = next_s.reset_source_status | reset_events;
    end
    case (s.mode)
      sisl_pkg::SISL_RUN: begin
        next_s.cnt = sisl_pkg::CNT_ZERO;
        if (stop_exec) begin
          next_s.mode = sisl_pkg::SISL_STOP;
          next_s.mclr = 1'b1;
        end else if (wait_exec) begin
          next_s.mode = sisl_pkg::SISL_WAIT;
          next_s.mclr = 1'b1;
        end
      end
      sisl_pkg::SISL_WAIT: begin
        if (break_request) begin
          next_s.brk_lp = 1'b1;
          next_s.mode   = sisl_pkg::SISL_RUN;
        end else if (|(s.req & src_enable) || any_rst) begin
          next_s.mode = sisl_pkg::SISL_RUN;
        end
      end
      sisl_pkg::SISL_STOP: begin
        next_s.cnt = sisl_pkg::CNT_ZERO;
        if (break_request) begin
          next_s.brk_lp = 1'b1;
          next_s.mode   = sisl_pkg::SISL_REC;
        end else if (|(s.req & src_enable)) begin
          next_s.mode = sisl_pkg::SISL_REC;
        end
      end
      sisl_pkg::SISL_REC: begin
        next_s.cnt = 13'(s.cnt + 13'h0001);
        if (s.cnt == (short_stop_recovery ? SHORT_CNT : LONG_CNT)) begin
          next_s.mode = sisl_pkg::SISL_RUN;
          next_s.cnt  = sisl_pkg::CNT_ZERO;
        end
      end
      default: next_s.mode = sisl_pkg::SISL_RUN;
    endcase
    // any reset ends low power at once and outranks interrupts
    if (any_rst) begin
      next_s.mode = sisl_pkg::SISL_RUN;
      next_s.cnt  = sisl_pkg::CNT_ZERO;
    end
    // vector request only while the cpu runs; stacking follows wake
    if (!any_rst && next_s.mode == sisl_pkg::SISL_RUN && s.mode != sisl_pkg::SISL_STOP) begin
      if (break_request || soft_int_request) begin
        next_s.take = 1'b1;
        next_s.vec  = 4'h0;
      end else if (|pend && !s.take) begin
        next_s.take = 1'b1;
        next_s.vec  = sisl_prio(pend);
      end
    end
    // register read data
    next_s.rdata = 32'h0000_0000;
    if (rd_acc) begin
      case (apb_req.paddr)
        sisl_pkg::OFS_BREAK_STATUS:  next_s.rdata[sisl_pkg::POS_BRK_LP] = s.brk_lp;
        sisl_pkg::OFS_RESET_STATUS:  next_s.rdata[7:0] = {s.reset_source_status, 2'b00};
        sisl_pkg::OFS_BREAK_FLAG:    next_s.rdata[sisl_pkg::POS_CLR_EN] = s.clr_en;
        sisl_pkg::OFS_INT_ONE:       next_s.rdata[7:0] = {s.req[5:0], 2'b00};
        sisl_pkg::OFS_INT_TWO:       next_s.rdata[4:0] = s.req[10:6];
        sisl_pkg::OFS_INT_THREE:     next_s.rdata[7:0] = 8'h00;
        sisl_pkg::OFS_LOWPOWER_CTRL: next_s.rdata[1:0] = s.mode;
        default:                     next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s       <= '0;
      s.mode  <= sisl_pkg::SISL_RUN;
      s.clr_en <= sisl_pkg::RST_BREAK_FLAG[sisl_pkg::POS_CLR_EN];
    end else begin
      s <= next_s;
    end
  end

  logic known;
  always_comb begin
    case (apb_req.paddr)
      sisl_pkg::OFS_BREAK_STATUS, sisl_pkg::OFS_RESET_STATUS, sisl_pkg::OFS_BREAK_FLAG,
      sisl_pkg::OFS_INT_ONE, sisl_pkg::OFS_INT_TWO, sisl_pkg::OFS_INT_THREE,
      sisl_pkg::OFS_LOWPOWER_CTRL: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // zero wait state slave; read data is the live decode of the state, not the rdata register
  assign pready  = 1'b1;
  assign pslverr = acc && !known;
  // rdata register lags one cycle, so present live decode in the access phase
  assign prdata  = next_s.rdata;

  // clock gating outputs
  assign cpu_clock_en      = (s.mode == sisl_pkg::SISL_RUN);
  assign periph_clock_en   = (s.mode != sisl_pkg::SISL_STOP);
  assign base_clock_out_en = (s.mode != sisl_pkg::SISL_STOP);
  assign crystal_clock_en  = (s.mode != sisl_pkg::SISL_STOP);
  assign watchdog_run      = !watchdog_disable_option && (s.mode != sisl_pkg::SISL_STOP);
  assign cpu_mask_clear    = s.mclr;
  assign vector_take       = s.take;
  assign vector_index      = s.vec;
  assign force_soft_vector = s.take && (s.vec == 4'h0) && s.brk;
  assign in_break          = s.brk;
  // other modules gate their clears with this; protection persists across two-step clears
  assign flag_clear_allowed = !s.brk || s.clr_en;

  // assertions
  rec_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mode == sisl_pkg::SISL_REC && s.cnt == SHORT_CNT && short_stop_recovery && !any_rst)
      |=> s.mode == sisl_pkg::SISL_RUN) else $error("short recovery wrong length");
  rec_cnt_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.mode == sisl_pkg::SISL_STOP |-> s.cnt == sisl_pkg::CNT_ZERO) else $error("counter not held in stop");
  stop_clk_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.mode == sisl_pkg::SISL_STOP |-> !crystal_clock_en && !base_clock_out_en && !cpu_clock_en)
    else $error("clocks live in stop");
  wait_clk_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.mode == sisl_pkg::SISL_WAIT |-> !cpu_clock_en && periph_clock_en) else $error("wait clock gating");
  mask_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mode == sisl_pkg::SISL_RUN && (wait_exec || stop_exec) && !any_rst) |=> cpu_mask_clear)
    else $error("mask not cleared");
  brk_lp_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mode == sisl_pkg::SISL_WAIT && break_request) |=> s.brk_lp) else $error("break lowpower flag not set");
  por_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    reset_events.power_on |=> s.reset_source_status == 6'b100000) else $error("power-on flags wrong");
  rsr_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && apb_req.paddr == sisl_pkg::OFS_RESET_STATUS && !any_rst) |=> s.reset_source_status == '0)
    else $error("reset status not cleared by read");
  interrupt_status_three_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && apb_req.paddr == sisl_pkg::OFS_INT_THREE) |-> prdata == 32'h0000_0000)
    else $error("third status nonzero");
  prot_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.brk && !s.clr_en) |-> !flag_clear_allowed) else $error("flags unprotected in break");

  stop_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
    s.mode == sisl_pkg::SISL_STOP ##1 s.mode == sisl_pkg::SISL_REC);
  wait_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
    s.mode == sisl_pkg::SISL_WAIT ##1 s.mode == sisl_pkg::SISL_RUN);
  vec_cov_c: cover property (@(posedge pclk) disable iff (!presetn) vector_take && vector_index != 4'h0);
endmodule // sisl_top

//--- sisl_cpu_model.sv
// cpu core and interrupt source model facing the sisl block
`timescale 1ns/1ns
module sisl_cpu_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        set_mask,
  input  wire logic [10:0] raise,
  input  wire logic [10:0] lower,
  input  wire logic        cpu_mask_clear,
  input  wire logic        vector_take,
  input  wire logic [3:0]  vector_index,
  output logic             cpu_mask_in,
  output logic [10:0]      src_request
);
  logic [10:0] ack;

  // a taken vector acknowledges its source; index 0 is software interrupt or break and owns no request
  assign ack = (vector_take && vector_index != 4'h0) ? (11'h001 << (vector_index - 4'h1)) : 11'h000;

  // mask leaves reset set, as the cpu does; requests hold until acknowledged or lowered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_mask_in <= 1'b1;
      src_request <= 11'h000;
    end else begin
      cpu_mask_in <= set_mask | (cpu_mask_in & ~cpu_mask_clear);
      src_request <= (src_request | raise) & ~lower & ~ack;
    end
  end
endmodule // sisl_cpu_model

//--- testbench.sv
// self-checking bench for the sisl block over apb with a cpu model
`timescale 1ns/1ns
module testbench;
  logic                       pclk, presetn, pready, pslverr, cpu_mask_in, cpu_mask_clear, cpu_clock_en;
  logic                       periph_clock_en, base_clock_out_en, crystal_clock_en, watchdog_run;
  logic                       vector_take, force_soft_vector, in_break, flag_clear_allowed;
  logic                       soft_int_request, break_request, wait_exec, stop_exec, set_mask;
  logic [31:0]                prdata;
  logic [10:0]                src_request, raise, lower;
  logic [3:0]                 vector_index;
  sisl_pkg::sisl_apb_req_type apb_req;
  sisl_pkg::sisl_rstsrc_type  reset_events;
  int                         err_count, n_tests;

  sisl_top uut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_request(src_request), .src_enable(11'h7FF), .cpu_mask_in(cpu_mask_in),
    .soft_int_request(soft_int_request), .break_request(break_request), .wait_exec(wait_exec),
    .stop_exec(stop_exec),
    .short_stop_recovery(1'b1), .watchdog_disable_option(1'b0), .reset_events(reset_events),
    .cpu_mask_clear(cpu_mask_clear), .cpu_clock_en(cpu_clock_en), .periph_clock_en(periph_clock_en),
    .base_clock_out_en(base_clock_out_en), .crystal_clock_en(crystal_clock_en), .watchdog_run(watchdog_run),
    .vector_take(vector_take), .vector_index(vector_index), .force_soft_vector(force_soft_vector),
    .in_break(in_break), .flag_clear_allowed(flag_clear_allowed));
  sisl_cpu_model cpu (.pclk(pclk), .presetn(presetn), .set_mask(set_mask), .raise(raise), .lower(lower),
    .cpu_mask_clear(cpu_mask_clear), .vector_take(vector_take), .vector_index(vector_index),
    .cpu_mask_in(cpu_mask_in), .src_request(src_request));

  // free running 125 mhz clock
  always #4 pclk = ~pclk;

  task automatic close_out;
    $display("errors %0d tests %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits for pready under a bound, never assumes the wait count
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd, output logic [32:0] r);
    int g;
    g = 0;
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    // look at the settled answer just ahead of the access edge, then pass that edge
    do begin
      @(negedge pclk);
      g++;
    end while (pready !== 1'b1 && g < 20);
    r = {pslverr, prdata};
    chk(pready, 1'b1);
    @(posedge pclk);
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic er);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, {er, 24'h0, e});
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [32:0] r;
    apb(1'b1, a, {24'h0, d}, r);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // waits for the next vector and compares its index and the break flag
  task automatic take(input logic [3:0] idx, input logic fs);
    int g;
    g = 0;
    do begin
      @(negedge pclk);
      g++;
    end while (vector_take !== 1'b1 && g < 60);
    chk({vector_take, vector_index, force_soft_vector}, {1'b1, idx, fs});
    @(posedge pclk);
  endtask

  task automatic pulse(input int k, input logic [10:0] v);
    if (k == 0) wait_exec <= 1'b1;
    if (k == 1) stop_exec <= 1'b1;
    if (k == 2) raise <= v;
    if (k == 3) lower <= v;
    @(posedge pclk);
    {wait_exec, stop_exec, raise, lower} <= '0;
  endtask

  // watchdog far beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    err_count++;
    close_out();
  end

  initial begin
    {pclk, presetn, soft_int_request, break_request, wait_exec, stop_exec, set_mask} = '0;
    {apb_req, reset_events, raise, lower} = '0;
    err_count = 0;
    n_tests = 0;
    tick(4);
    presetn <= 1'b1;
    chk({cpu_clock_en, periph_clock_en, base_clock_out_en, crystal_clock_en, watchdog_run}, 5'h1F);
    rd(sisl_pkg::OFS_INT_ONE, sisl_pkg::RST_INT_ONE, 1'b0);
    rd(sisl_pkg::OFS_BREAK_FLAG, sisl_pkg::RST_BREAK_FLAG, 1'b0);
    // live request levels, with the cpu mask set so nothing is taken
    pulse(2, 11'h5A5);
    tick(2);
    rd(sisl_pkg::OFS_INT_ONE, 8'h94, 1'b0);
    wr(sisl_pkg::OFS_INT_ONE, 8'hFF);
    rd(sisl_pkg::OFS_INT_ONE, 8'h94, 1'b0);
    rd(sisl_pkg::OFS_INT_TWO, 8'h16, 1'b0);
    rd(sisl_pkg::OFS_INT_THREE, 8'h00, 1'b0);
    pulse(3, 11'h7FF);
    tick(2);
    rd(sisl_pkg::OFS_INT_TWO, 8'h00, 1'b0);
    rd(16'hFE02, 8'h00, 1'b1);
    // each reset source sets its own flag; a read clears them all
    for (int i = 0; i < 6; i++) begin
      reset_events <= 6'h20 >> i;
      tick(1);
      reset_events <= '0;
      rd(sisl_pkg::OFS_RESET_STATUS, 8'h80 >> i, 1'b0);
      rd(sisl_pkg::OFS_RESET_STATUS, 8'h00, 1'b0);
    end
    reset_events <= 6'h08;
    tick(1);
    reset_events <= 6'h20;
    tick(1);
    reset_events <= '0;
    rd(sisl_pkg::OFS_RESET_STATUS, 8'h80, 1'b0);
    // break forces the software interrupt vector and protects flags until clear enable is set
    break_request <= 1'b1;
    take(4'h0, 1'b1);
    chk({in_break, flag_clear_allowed}, 2'b10);
    wr(sisl_pkg::OFS_BREAK_FLAG, 8'h80);
    tick(1);
    chk(flag_clear_allowed, 1'b1);
    rd(sisl_pkg::OFS_BREAK_FLAG, 8'h80, 1'b0);
    break_request <= 1'b0;
    wr(sisl_pkg::OFS_BREAK_FLAG, 8'h00);
    tick(2);
    chk({in_break, flag_clear_allowed}, 2'b01);
    // wait, left by break: lowpower flag set, then cleared by writing zero
    pulse(0, 11'h0);
    tick(2);
    chk({cpu_clock_en, periph_clock_en, watchdog_run, cpu_mask_in}, 4'b0110);
    rd(sisl_pkg::OFS_LOWPOWER_CTRL, 8'h01, 1'b0);
    break_request <= 1'b1;
    tick(3);
    break_request <= 1'b0;
    tick(2);
    rd(sisl_pkg::OFS_BREAK_STATUS, 8'h02, 1'b0);
    wr(sisl_pkg::OFS_BREAK_STATUS, 8'h00);
    rd(sisl_pkg::OFS_BREAK_STATUS, 8'h00, 1'b0);
    // wait, left by an enabled request
    pulse(0, 11'h0);
    tick(2);
    pulse(2, 11'h002);
    take(4'h2, 1'b0);
    rd(sisl_pkg::OFS_LOWPOWER_CTRL, 8'h00, 1'b0);
    // two requests together: lower number first
    pulse(2, 11'h014);
    take(4'h3, 1'b0);
    take(4'h5, 1'b0);
    // mask blocks sources but not the software interrupt
    set_mask <= 1'b1;
    pulse(2, 11'h001);
    set_mask <= 1'b0;
    tick(4);
    rd(sisl_pkg::OFS_INT_ONE, 8'h04, 1'b0);
    soft_int_request <= 1'b1;
    take(4'h0, 1'b0);
    soft_int_request <= 1'b0;
    pulse(3, 11'h001);
    // stop with short recovery: clocks off, request waits out the 32 cycles
    pulse(1, 11'h0);
    tick(2);
    chk({base_clock_out_en, crystal_clock_en, cpu_mask_in}, 3'b000);
    rd(sisl_pkg::OFS_LOWPOWER_CTRL, 8'h03, 1'b0);
    pulse(2, 11'h400);
    tick(16);
    rd(sisl_pkg::OFS_LOWPOWER_CTRL, 8'h02, 1'b0);
    rd(sisl_pkg::OFS_INT_TWO, 8'h10, 1'b0);
    tick(20);
    rd(sisl_pkg::OFS_LOWPOWER_CTRL, 8'h00, 1'b0);
    rd(sisl_pkg::OFS_INT_TWO, 8'h00, 1'b0);
    close_out();
  end
endmodule // testbench
